// *** hw/tocc_map.vh ***
`ifndef TOCC_MAP_VH
`define TOCC_MAP_VH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define TOCC_ADDR_CTL1      12'h538
`define TOCC_ADDR_INDEX     12'h500
`define TOCC_ADDR_TSCTL     12'h504
`define TOCC_ADDR_TARGET    12'h510
`define TOCC_ADDR_SYSTIME   12'h514
`define TOCC_ADDR_STATUS    12'h520
`define TOCC_ADDR_IRQ_EN    12'h524
`define TOCC_ADDR_IRQ_CLR   12'h528
// ----------------------------------------------------------------
// control 1 field positions
// ----------------------------------------------------------------
`define TOCC_BIT_CHAIN_EN   31
`define TOCC_BIT_TAIL       30
`define TOCC_BIT_UPSEL_HI   27
`define TOCC_BIT_UPSEL_LO   26
`define TOCC_BIT_NOW        25
`define TOCC_BIT_NOTIFY     24
`define TOCC_BIT_EDGE       23
`define TOCC_CTL1_MASK      32'hCF800000
`define TOCC_CTL1_RESET     32'h00000000
// ----------------------------------------------------------------
// timestamp control bits, index pointer, status layout
// ----------------------------------------------------------------
`define TOCC_BIT_ACTIVE     4
`define TOCC_BIT_UNIT_EN    3
`define TOCC_BIT_SOFT_RST   2
`define TOCC_IDX_HI         1
`define TOCC_IDX_LO         0
`define TOCC_ST_DONE_LO     0
`define TOCC_ST_FAULT_LO    4
// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define TOCC_RESP_OKAY      2'h0
`define TOCC_RESP_SLVERR    2'h2
`endif

// *** hw/tocc_unit.v ***
`timescale 1ns/10ps
`include "tocc_map.vh"
// one trigger output unit: start, fire, repeat, flag
module tocc_unit #(
  parameter TW = 32
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // configuration
  input  wire          chain_enable,
  input  wire          tail,
  input  wire          fire_now,
  input  wire          notify,
  input  wire          unit_soft_reset,
  input  wire [15:0]   iter_count,
  input  wire          any_tail,
  // start sources
  input  wire          arm,
  input  wire          upstream_done,
  input  wire [TW-1:0] target_time,
  input  wire [TW-1:0] sys_time,
  // results
  output reg           active,
  output reg           fire,
  output reg           done_pulse,
  output reg           fault_pulse,
  output reg           link_pulse   // start pulse for followers
);
  reg [15:0] iters;   // completed passes while tail
  wire       reached;
  wire       past;
  assign reached = (sys_time == target_time);
  assign past    = (sys_time > target_time);
  // ----------------------------------------------------------------
  // unit sequencer
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    fire        <= 1'b0;
    done_pulse  <= 1'b0;
    fault_pulse <= 1'b0;
    link_pulse  <= 1'b0;
    if (!aresetn || unit_soft_reset) begin // [RULE13]
      active <= 1'b0;
      iters  <= 16'h0000;
    end else if (!active) begin
      // standalone units start from software, chained ones from software or upstream
      if (arm || (chain_enable && upstream_done)) begin // [RULE1] [RULE12]
        active <= 1'b1;
      end
    end else if (reached || (past && fire_now)) begin // [RULE7] [RULE8] [RULE14]
      fire        <= 1'b1;
      active      <= 1'b0;
      done_pulse  <= notify; // [RULE9]
      // last tail pass sends no link, so the chain stops [RULE2] [RULE3]
      link_pulse  <= !(chain_enable && tail && any_tail && (iters == iter_count));
      if (chain_enable && tail && any_tail) begin // [RULE2]
        iters <= (iters == iter_count) ? 16'h0000 : iters + 16'h0001;
      end
    end else if (past && !fire_now) begin
      // target already gone and no late firing allowed: fault
      active      <= 1'b0;
      fault_pulse <= notify; // [RULE9]
    end
  end
  // no tail anywhere: count is ignored and the loop never ends [RULE3]
endmodule // tocc_unit

// *** hw/tocc_edge.v ***
`timescale 1ns/10ps
`include "tocc_map.vh"
// output stage: toggles on rising or falling edge by selection
module tocc_edge (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // control
  input  wire fall_sel,
  input  wire fire,
  // output
  output reg  trig_out
);
  reg pos_q;  // rising edge copy
  reg neg_q;  // falling edge copy
  // ----------------------------------------------------------------
  // rising edge stage
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) pos_q <= 1'b0;
    else if (fire) pos_q <= ~pos_q;
  end
  // ----------------------------------------------------------------
  // falling edge stage, fed from rising copy
  // ----------------------------------------------------------------
  always @(negedge aclk) begin
    if (!aresetn) neg_q <= 1'b0;
    else neg_q <= pos_q;
  end
  // pick which stage drives the pin
  always @* begin
    trig_out = fall_sel ? neg_q : pos_q; // [RULE10]
  end
endmodule // tocc_edge

// *** hw/tocc_top.v ***
`timescale 1ns/10ps
`include "tocc_map.vh"
// --------------------------------------------------------------------
// Overview of operation
// RULE1: chain enable selects cascade or standalone
// RULE2: tail bit marks last unit of chain
// RULE3: no tail anywhere means endless repetition
// RULE4: software soft reset ends an endless loop
// RULE5: upstream select picks starting done signal
// RULE6: software programs upstream selects to close loop
// RULE7: immediate bit fires when target already past
// RULE8: otherwise wait until system time reaches target
// RULE9: notify gates done, fault flags, interrupt
// RULE10: edge bit selects falling or rising output
// RULE11: accesses go to unit chosen by index
// RULE12: software enables only the chain head
// RULE13: soft reset returns unit to defaults
// RULE14: enabled unit fires when times meet
// --------------------------------------------------------------------
module tocc_top #(
  parameter NU = 3,   // number of trigger units
  parameter TW = 32   // time width
) (
  // clock and reset
  input  wire          aclk,
  input  wire          aresetn,
  // write address channel
  input  wire [11:0]   s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  // write data channel
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  // write response channel
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // read address channel
  input  wire [11:0]   s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  // read data channel
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // time and outputs
  input  wire [TW-1:0] sys_time,
  output reg  [NU-1:0] trig_out,
  output reg           irq
);
  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  reg  [31:0]   ctl1 [0:NU-1];   // per unit control 1
  reg  [TW-1:0] target [0:NU-1]; // per unit target time
  reg  [15:0]   iter [0:NU-1];   // per unit iteration count
  reg  [1:0]    unit_idx;        // indexed access pointer
  reg  [NU-1:0] soft_rst;        // per unit soft reset
  reg  [NU-1:0] arm;             // one cycle start pulse
  reg  [NU-1:0] unit_finished_flag; // sticky done
  reg  [NU-1:0] unit_fault_flag;    // sticky fault
  reg  [7:0]    irq_en;          // interrupt enables
  reg  [11:0]   aw_addr;         // captured write address
  reg           aw_have;         // write address held
  reg  [31:0]   w_data;          // captured write data
  reg  [3:0]    w_strb;          // captured strobes
  reg           w_have;          // write data held
  wire [NU-1:0] active;
  wire [NU-1:0] fire;
  wire [NU-1:0] done_p;
  wire [NU-1:0] fault_p;
  wire [NU-1:0] pin;
  wire [NU-1:0] up_done;
  wire [NU-1:0] link_p;          // start pulse to followers
  wire          any_tail;
  wire [7:0]    status_w;
  reg  [NU-1:0] tails;
  integer       k;

  // merge byte strobes into an old value
  function [31:0] tocc_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer b;
    begin
      // lanes without a strobe keep old bytes
      tocc_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) tocc_merge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  // select link pulse of upstream unit, code n in 1..3 is unit n-1, 0 none
  function tocc_pick;
    input [1:0]    sel;
    input [NU-1:0] done_v;
    begin
      tocc_pick = (sel == 2'h0) ? 1'b0 : done_v[sel - 2'h1];
    end
  endfunction

  // ------------------------------------------------------------------
  // cascade wiring
  // ------------------------------------------------------------------
  // tail counts only on a chained unit
  always @* begin
    for (k = 0; k < NU; k = k + 1) begin
      tails[k] = ctl1[k][`TOCC_BIT_CHAIN_EN] & ctl1[k][`TOCC_BIT_TAIL];
    end
  end
  assign any_tail = |tails; // [RULE3]

  // one sequencer and one edge stage per unit
  genvar g;
  generate
    for (g = 0; g < NU; g = g + 1) begin : gu
      // upstream unit chosen by two-bit select
      // a finished tail sends no link, ending the chain
      assign up_done[g] = tocc_pick(ctl1[g][`TOCC_BIT_UPSEL_HI:`TOCC_BIT_UPSEL_LO], link_p); // [RULE5]
      tocc_unit #(.TW(TW)) u_unit (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .chain_enable    (ctl1[g][`TOCC_BIT_CHAIN_EN]),
        .tail            (ctl1[g][`TOCC_BIT_TAIL]),
        .fire_now        (ctl1[g][`TOCC_BIT_NOW]),
        .notify          (ctl1[g][`TOCC_BIT_NOTIFY]),
        .unit_soft_reset (soft_rst[g]),
        .iter_count      (iter[g]),
        .any_tail        (any_tail),
        .arm             (arm[g]),
        .upstream_done   (up_done[g]),
        .target_time     (target[g]),
        .sys_time        (sys_time),
        .active          (active[g]),
        .fire            (fire[g]),
        .done_pulse      (done_p[g]),
        .fault_pulse     (fault_p[g]),
        .link_pulse      (link_p[g])
      );
      tocc_edge u_edge (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .fall_sel (ctl1[g][`TOCC_BIT_EDGE]),
        .fire     (fire[g]),
        .trig_out (pin[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // output stage
  // ------------------------------------------------------------------
  // pins pass straight from the edge flops so a
  // falling-edge change is not moved to a rising one
  always @* begin
    trig_out = pin; // [RULE10]
  end

  // interrupt level
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_w & irq_en); // [RULE9]
    end
  end

  // ------------------------------------------------------------------
  // write path: address and data in either order
  // ------------------------------------------------------------------
  // answer waits for both halves
  wire wr_go;
  assign wr_go = aw_have && w_have && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TOCC_RESP_OKAY;
    end else begin
      // each ready offered only while its own half is not held
      s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit(aw_addr) ? `TOCC_RESP_OKAY : `TOCC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // decode of writable addresses
  function wr_hit;
    input [11:0] a;
    begin
      wr_hit = (a == `TOCC_ADDR_CTL1) || (a == `TOCC_ADDR_INDEX) ||
               (a == `TOCC_ADDR_TSCTL) || (a == `TOCC_ADDR_TARGET) ||
               (a == `TOCC_ADDR_IRQ_EN) || (a == `TOCC_ADDR_IRQ_CLR);
    end
  endfunction

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  // merged write words
  wire [31:0] wv_ctl;
  wire [31:0] wv_ts;
  wire [31:0] wv_iter;
  assign wv_ctl  = tocc_merge(ctl1[unit_idx], w_data, w_strb) & `TOCC_CTL1_MASK;
  assign wv_ts   = tocc_merge(32'h00000000, w_data, w_strb);
  assign wv_iter = tocc_merge({16'h0000, iter[unit_idx]}, w_data, w_strb);

  always @(posedge aclk) begin
    // enable and soft reset are one-cycle pulses
    arm      <= {NU{1'b0}};
    soft_rst <= {NU{1'b0}};
    if (!aresetn) begin
      unit_idx <= 2'h0;
      irq_en   <= 8'h00;
      for (k = 0; k < NU; k = k + 1) begin
        ctl1[k]   <= `TOCC_CTL1_RESET;
        target[k] <= {TW{1'b0}};
        iter[k]   <= 16'h0000;
      end
    end else begin
      for (k = 0; k < NU; k = k + 1) begin
        // soft reset restores default settings of that unit [RULE13]
        if (soft_rst[k]) begin
          ctl1[k]   <= `TOCC_CTL1_RESET;
          target[k] <= {TW{1'b0}};
          iter[k]   <= 16'h0000;
        end
      end
      // index 3 names no unit: unit register writes dropped
      if (wr_go && unit_idx < NU) begin
        case (aw_addr)
          `TOCC_ADDR_CTL1: begin
            ctl1[unit_idx] <= wv_ctl;                       // [RULE11]
            iter[unit_idx] <= wv_iter[15:0];
          end
          `TOCC_ADDR_TARGET: begin
            target[unit_idx] <= wv_ts[TW-1:0];              // [RULE11]
          end
          `TOCC_ADDR_TSCTL: begin
            // enable and soft reset act on the indexed unit [RULE4]
            arm[unit_idx]      <= wv_ts[`TOCC_BIT_UNIT_EN];  // [RULE11]
            soft_rst[unit_idx] <= wv_ts[`TOCC_BIT_SOFT_RST]; // [RULE13]
          end
          default: begin
          end
        endcase
      end
      if (wr_go && aw_addr == `TOCC_ADDR_INDEX) begin
        unit_idx <= wv_ts[`TOCC_IDX_HI:`TOCC_IDX_LO];
      end
      if (wr_go && aw_addr == `TOCC_ADDR_IRQ_EN) begin
        irq_en <= wv_ts[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // sticky status: set wins over clear
  // ------------------------------------------------------------------
  // write one to clear
  wire [7:0] clr_v;
  assign clr_v = (wr_go && aw_addr == `TOCC_ADDR_IRQ_CLR) ? wv_ts[7:0] : 8'h00;

  always @(posedge aclk) begin
    if (!aresetn) begin
      unit_finished_flag <= {NU{1'b0}};
      unit_fault_flag    <= {NU{1'b0}};
    end else begin
      unit_finished_flag <= (unit_finished_flag & ~clr_v[NU-1:0]) | done_p;  // [RULE9]
      unit_fault_flag    <= (unit_fault_flag & ~clr_v[`TOCC_ST_FAULT_LO +: NU]) | fault_p; // [RULE9]
    end
  end
  // done in 2:0, fault in 6:4
  assign status_w = {1'b0, unit_fault_flag, 1'b0, unit_finished_flag};

  // ------------------------------------------------------------------
  // read path: one cycle after address acceptance
  // ------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TOCC_RESP_OKAY;
    end else begin
      // one read in flight at a time
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `TOCC_RESP_OKAY;
        case (s_axi_araddr)
          `TOCC_ADDR_CTL1:    s_axi_rdata <= (unit_idx < NU) ?
                                (ctl1[unit_idx] | {16'h0000, iter[unit_idx]}) : 32'h00000000; // [RULE11]
          `TOCC_ADDR_INDEX:   s_axi_rdata <= {30'h00000000, unit_idx};
          `TOCC_ADDR_TSCTL:   s_axi_rdata <= (unit_idx < NU) ?
                                ({27'h0000000, active[unit_idx], 4'h0}) : 32'h00000000;
          `TOCC_ADDR_TARGET:  s_axi_rdata <= (unit_idx < NU) ? target[unit_idx] : 32'h00000000;
          `TOCC_ADDR_SYSTIME: s_axi_rdata <= sys_time;
          `TOCC_ADDR_STATUS:  s_axi_rdata <= {24'h000000, status_w};
          `TOCC_ADDR_IRQ_EN:  s_axi_rdata <= {24'h000000, irq_en};
          `TOCC_ADDR_IRQ_CLR: s_axi_rdata <= 32'h00000000;
          // unmapped: error, zero data
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TOCC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // upstream select values that close a loop are software's job [RULE6]
endmodule // tocc_top

// *** tb/tocc_checker.sv ***
`timescale 1ns/10ps
`include "tocc_map.vh"
// ------------------------------
// port checks of the trigger block
// ------------------------------
module tocc_checker #(
  parameter NU = 3,
  parameter TW = 32
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // write side
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read side
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // interrupt
  input wire logic        irq
);
  // one domain, so clock and reset are stated once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken in one cycle
  wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire rd_hs = s_axi_arvalid && s_axi_arready;
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer withdrawn early");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer withdrawn early");
  AST_WR_ANSWER: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (rd_hs |=> s_axi_rvalid)
    else $error("read answer late");
  AST_UNMAPPED: assert property (rd_hs && s_axi_araddr == 12'h600 |=> s_axi_rresp == `TOCC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_MAPPED_OK: assert property (rd_hs && s_axi_araddr == `TOCC_ADDR_CTL1 |=> s_axi_rresp == `TOCC_RESP_OKAY)
    else $error("control read refused");
  AST_IDX_OKAY: assert property (wr_hs && s_axi_awaddr == `TOCC_ADDR_INDEX |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("index write refused");
  AST_IRQ_DROP: assert property (wr_hs && s_axi_awaddr == `TOCC_ADDR_IRQ_EN && s_axi_wdata == 32'h0 |-> ##[1:3] !irq)
    else $error("interrupt stays with all enables off");
endmodule // tocc_checker

bind tocc_top tocc_checker #(.NU(NU), .TW(TW)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
);

// *** tb/tocc_tb.sv ***
`timescale 1ns/10ps
`include "tocc_map.vh"
module tb;
  // ------------------------------
  // design signals
  // ------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [31:0] sys_time = 32'h0;
  logic [2:0]  trig_out;
  logic        irq;
  // ------------------------------
  // bench state and model
  // ------------------------------
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          togs[3];            // output changes per unit
  int          snap[3];            // saved change counts
  int          m_ctl[3];           // model of indexed control words
  int          m_st = 0;           // model of sticky status
  int          m_en = 0;           // model of interrupt enable
  int          upsel[3] = '{3, 1, 2};
  logic [2:0]  prev_t = 3'h0;
  logic        tog_clk;            // clock level at last output change
  logic [31:0] lf = 32'h7;         // random source state
  logic [31:0] rd;
  logic [1:0]  rr;

  tocc_top #(.NU(3), .TW(32)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sys_time(sys_time), .trig_out(trig_out), .irq(irq)
  );

  // 50 ns period
  always #25 aclk = ~aclk;

  // count output changes; reset-time settling is ignored
  always @(trig_out) begin
    for (int i = 0; i < 3; i++)
      if (trig_out[i] !== prev_t[i] && aresetn) togs[i]++;
    prev_t = trig_out;
    tog_clk = aclk;
  end

  // hang guard, well above the whole sequence
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      final_report;
    end
  end

  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report;
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // program one unit through the index pointer
  task automatic cfg(input int i, input logic [31:0] c, input logic [31:0] t);
    wr(`TOCC_ADDR_INDEX, i);
    wr(`TOCC_ADDR_TARGET, t);
    wr(`TOCC_ADDR_CTL1, c);
    m_ctl[i] = c;
  endtask

  task automatic arm(input int i);
    wr(`TOCC_ADDR_INDEX, i);
    wr(`TOCC_ADDR_TSCTL, 32'h8);
  endtask

  task automatic wait_tog(input int i, input int n);
    for (int k = 0; k < 300 && togs[i] < n; k++) @(posedge aclk);
  endtask

  // status word and interrupt level against the model
  task automatic st;
    rdr(`TOCC_ADDR_STATUS);
    chk(rd, m_st);
    chk(irq, |(m_st & m_en));
  endtask

  task automatic take_snap;
    for (int i = 0; i < 3; i++) snap[i] = togs[i];
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // defaults, then random words kept apart per index
    for (int i = 0; i < 3; i++) begin
      wr(`TOCC_ADDR_INDEX, i);
      rdr(`TOCC_ADDR_CTL1);
      chk(rd & `TOCC_CTL1_MASK, `TOCC_CTL1_RESET);
      lf = lfsr(lf);
      wr(`TOCC_ADDR_CTL1, lf << 23);
      m_ctl[i] = lf << 23;
    end
    for (int i = 0; i < 3; i++) begin
      wr(`TOCC_ADDR_INDEX, i);
      rdr(`TOCC_ADDR_CTL1);
      chk(rd & `TOCC_CTL1_MASK, m_ctl[i] & `TOCC_CTL1_MASK);
    end
    rdr(12'h600);
    chk(rr, `TOCC_RESP_SLVERR);
    // standalone wait for the target, rising output edge
    wr(`TOCC_ADDR_IRQ_EN, 32'h1);
    m_en = 1;
    sys_time <= 32'h32;
    cfg(0, 32'h01000000, 32'h64);
    arm(0);
    repeat (20) @(posedge aclk);
    chk(togs[0], 0);
    st();
    sys_time <= 32'h64;
    wait_tog(0, 1);
    chk(togs[0], 1);
    chk(tog_clk, 1'b1);
    m_st = 1;
    st();
    // interrupt masked, unmasked, cleared
    wr(`TOCC_ADDR_IRQ_EN, 32'h0);
    m_en = 0;
    st();
    wr(`TOCC_ADDR_IRQ_EN, 32'h77);
    m_en = 32'h77;
    st();
    wr(`TOCC_ADDR_IRQ_CLR, 32'h1);
    m_st = 0;
    st();
    // past target with immediate bit, falling output edge
    cfg(1, 32'h03800000, 32'hA);
    arm(1);
    wait_tog(1, 1);
    chk(togs[1], 1);
    chk(tog_clk, 1'b0);
    m_st = 2;
    st();
    // past target without immediate bit: no output, fault flag
    cfg(2, 32'h01000000, 32'hA);
    arm(2);
    repeat (20) @(posedge aclk);
    chk(togs[2], 0);
    m_st = 32'h42;
    st();
    // notify off: fires but reports nothing
    wr(`TOCC_ADDR_IRQ_CLR, 32'h77);
    m_st = 0;
    cfg(1, 32'h02000000, 32'hA);
    arm(1);
    wait_tog(1, 2);
    chk(togs[1], 2);
    st();
    // closed chain with no tail loops until soft reset
    for (int i = 0; i < 3; i++) cfg(i, 32'h82000000 | (upsel[i] << 26), 32'hA);
    take_snap();
    arm(0);
    wait_tog(2, snap[2] + 3);
    for (int i = 0; i < 3; i++) chk(togs[i] >= snap[i] + 3, 1);
    // twice round, so a late upstream done cannot restart a unit
    repeat (2)
      for (int i = 0; i < 3; i++) begin
        wr(`TOCC_ADDR_INDEX, i);
        wr(`TOCC_ADDR_TSCTL, 32'h4);
      end
    take_snap();
    repeat (50) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      chk(togs[i], snap[i]);
      wr(`TOCC_ADDR_INDEX, i);
      rdr(`TOCC_ADDR_TSCTL);
      chk(rd[4], 1'b0);
      rdr(`TOCC_ADDR_CTL1);
      chk(rd & `TOCC_CTL1_MASK, `TOCC_CTL1_RESET);
    end
    // same chain with a tail and one pass: it must stop by itself
    for (int i = 0; i < 3; i++) cfg(i, 32'h82000000 | (upsel[i] << 26) | (i == 2 ? 32'h40000000 : 32'h0), 32'hA);
    take_snap();
    arm(0);
    repeat (150) @(posedge aclk);
    chk(togs[2] > snap[2], 1);
    take_snap();
    repeat (50) @(posedge aclk);
    for (int i = 0; i < 3; i++) chk(togs[i], snap[i]);
    final_report;
  end
endmodule // tb
